/* shared/cers_map.svh */
// Constants for the rotate, subtract and skip execution block
`ifndef CERS_MAP_SVH
`define CERS_MAP_SVH

// ----------------------------------------------------------------
// Byte layout
// ----------------------------------------------------------------
`define CERS_BYTE_ONES 8'hff
`define CERS_BYTE_ZERO 8'h00
`define CERS_BYTE_ONE 8'h01
`define CERS_MSB 7
`define CERS_LSB 0
`define CERS_HALF_MSB 3
`define CERS_HALF_LSB 4

// ----------------------------------------------------------------
// Reset values and the interrupt-enable set value
// ----------------------------------------------------------------
`define CERS_WREG_RESET 8'h00
`define CERS_FLAGS_RESET 4'h0
`define CERS_MIE_RESET 1'b0
`define CERS_MIE_SET 1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CERS_SKIP_CYCLES 2
`define CERS_PC_W_MAX 16

`endif

/* shared/cers_pkg.sv */
// Types shared by the rotate, subtract and skip execution block
package cers_pkg;

  // ----------------------------------------------------------------
  // Operations handed over by the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_none,
    op_return_with_immediate,
    op_return_from_irq,
    op_rotate_left,
    op_rotate_left_to_wreg,
    op_rotate_left_thru_carry,
    op_rotate_left_thru_carry_wreg,
    op_rotate_right,
    op_rotate_right_to_wreg,
    op_rotate_right_thru_carry,
    op_rotate_right_thru_carry_wreg,
    op_subtract_with_borrow,
    op_subtract_with_borrow_to_mem,
    op_subtract_mem,
    op_subtract_to_mem,
    op_subtract_imm,
    op_decrement_skip_zero,
    op_decrement_skip_zero_wreg,
    op_increment_skip_zero,
    op_increment_skip_zero_wreg,
    op_set_byte,
    op_set_bit,
    op_bit_test_skip_nonzero,
    op_swap_nibbles
  } cers_op_t;

  // Status flags, also used as an update mask
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } cers_flags_t;

  // One instruction request
  typedef struct packed {
    logic valid;
    cers_op_t op;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } cers_req_t;

  // Dummy-cycle sequencer states
  typedef enum logic {
    cers_skip_idle,
    cers_skip_dummy
  } cers_skip_state_t;

endpackage

/* rtl/cers_skip.sv */
// Dummy-cycle sequencer for conditional-skip instructions
`include "cers_map.svh"

module cers_skip
  import cers_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic take_in,
  output logic ready_out,
  output logic skip_out,
  output logic dummy_out
);

  cers_skip_state_t state;

  // ----------------------------------------------------------------
  // Two-cycle sequence
  // ----------------------------------------------------------------
  // Second cycle is always spent, taken or not, so timing stays fixed
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= cers_skip_idle;
      ready_out <= 1'b1;
      skip_out <= 1'b0;
      dummy_out <= 1'b0;
    end else begin
      unique case (state)
        cers_skip_idle: begin
          if (start_in) begin
            state <= cers_skip_dummy;
            ready_out <= 1'b0;
            skip_out <= take_in;
            dummy_out <= 1'b1;
          end
        end
        cers_skip_dummy: begin
          state <= cers_skip_idle;
          ready_out <= 1'b1;
          skip_out <= 1'b0;
          dummy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* rtl/cers_ret.sv */
// Return handling: stack pop, resume address and interrupt enable
`include "cers_map.svh"

module cers_ret
  import cers_pkg::*;
#(
  parameter int PC_W = 13
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic from_irq_in,
  input wire logic irq_pending_in,
  input wire logic irq_entry_in,
  input wire logic [PC_W-1:0] stack_top_in,
  output logic stack_pop_out,
  output logic pc_load_out,
  output logic [PC_W-1:0] pc_out,
  output logic irq_service_out,
  output logic master_irq_enable_out
);

  // ----------------------------------------------------------------
  // Pop and resume
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stack_pop_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_out <= '0;
      irq_service_out <= 1'b0;
    end else begin
      stack_pop_out <= start_in;
      pc_load_out <= start_in;
      if (start_in) begin
        pc_out <= stack_top_in;
      end
      // Pending request goes first; pc_out is then its return address
      irq_service_out <= start_in && from_irq_in && irq_pending_in;
    end
  end

  // ----------------------------------------------------------------
  // Master enable: a return from interrupt sets it, interrupt entry clears it
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      master_irq_enable_out <= `CERS_MIE_RESET;
    end else if (start_in && from_irq_in) begin
      master_irq_enable_out <= `CERS_MIE_SET;
    end else if (irq_entry_in) begin
      master_irq_enable_out <= 1'b0;
    end
  end

endmodule

/* rtl/cers_exec.sv */
// Execution block for returns, rotates, subtracts, skips, bit set and swap
`include "cers_map.svh"

module cers_exec
  import cers_pkg::*;
#(
  parameter int PC_W = 13
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire cers_req_t exec_in,
  input wire logic [PC_W-1:0] stack_top_in,
  input wire logic irq_pending_in,
  input wire logic irq_entry_in,
  output logic ready_out,
  output logic [7:0] wreg_out,
  output cers_flags_t flags_out,
  output logic master_irq_enable_out,
  output logic mem_we_out,
  output logic [7:0] mem_wdata_out,
  output logic pc_load_out,
  output logic [PC_W-1:0] pc_out,
  output logic stack_pop_out,
  output logic irq_service_out,
  output logic skip_out,
  output logic dummy_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Stack width caps PC_W
  if (PC_W < 1 || PC_W > `CERS_PC_W_MAX) begin : g_bad_pc_w
    $error("cers_exec: PC_W out of range");
  end

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  // Left rotate; the incoming bit is the wrapped msb or the carry
  function automatic logic [7:0] rot_left(input logic [7:0] v, input logic in_bit);
    rot_left = {v[`CERS_MSB-1:`CERS_LSB], in_bit};
  endfunction

  // Right rotate; the incoming bit is the wrapped lsb or the carry
  function automatic logic [7:0] rot_right(input logic [7:0] v, input logic in_bit);
    rot_right = {in_bit, v[`CERS_MSB:`CERS_LSB+1]};
  endfunction

  // Subtract a minus b minus borrow, returning result and flags
  function automatic logic [11:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic borrow);
    logic [8:0] full;
    logic [4:0] low;
    cers_flags_t f;
    // Bit 8 is the borrow
    full = {1'b0, a} - {1'b0, b} - {8'h00, borrow};
    // Bit 4 is the nibble borrow
    low = {1'b0, a[`CERS_HALF_MSB:0]} - {1'b0, b[`CERS_HALF_MSB:0]} - {4'h0, borrow};
    // Carry and half-carry are borrows inverted
    f.carry_flag = ~full[8];
    f.half_carry_flag = ~low[4];
    f.zero_flag = (full[7:0] == `CERS_BYTE_ZERO);
    f.overflow_flag = (a[`CERS_MSB] ^ b[`CERS_MSB]) & (a[`CERS_MSB] ^ full[`CERS_MSB]);
    sub_flags = {f, full[7:0]};
  endfunction

  // One-hot mask for a bit position
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = `CERS_BYTE_ONE << sel;
  endfunction

  // ----------------------------------------------------------------
  // Request acceptance and operation classes
  // ----------------------------------------------------------------
  logic accept;
  logic is_ret;
  logic is_return_from_irq;
  logic is_skip;
  logic skip_ready;

  // A request is only taken while no dummy cycle is running
  assign accept = exec_in.valid && skip_ready;
  // Both returns share one pop unit
  assign is_return_from_irq = (exec_in.op == op_return_from_irq);
  assign is_ret = is_return_from_irq || (exec_in.op == op_return_with_immediate);

  // ----------------------------------------------------------------
  // Datapath decode
  // ----------------------------------------------------------------
  // Settled within the accept cycle
  logic [7:0] next_result;
  logic wr_mem;
  logic wr_wreg;
  logic take_skip;
  cers_flags_t next_flags;
  cers_flags_t flag_upd;
  logic [11:0] sub_res;
  logic [7:0] sub_rhs;
  logic sub_borrow;

  // Subtractor operand choice; borrow is the inverted carry for the carry forms
  always_comb begin
    sub_rhs = exec_in.mem_data;
    sub_borrow = 1'b0;
    unique case (exec_in.op)
      // Borrow is inverted carry
      op_subtract_with_borrow, op_subtract_with_borrow_to_mem: begin
        sub_borrow = ~flags_out.carry_flag;
      end
      // Immediate operand
      op_subtract_imm: begin
        sub_rhs = exec_in.imm;
      end
      // Memory, no borrow
      default: begin
        sub_borrow = 1'b0;
      end
    endcase
  end

  // One subtractor for all forms
  assign sub_res = sub_flags(wreg_out, sub_rhs, sub_borrow);

  // Result, destination, flag mask and skip decision per operation
  always_comb begin
    // No write, no skip, flags kept
    next_result = exec_in.mem_data;
    wr_mem = 1'b0;
    wr_wreg = 1'b0;
    take_skip = 1'b0;
    is_skip = 1'b0;
    next_flags = flags_out;
    flag_upd = '0;
    unique case (exec_in.op)
      // Idle slot
      op_none: begin
        next_result = exec_in.mem_data;
      end
      // Immediate to wreg
      op_return_with_immediate: begin
        next_result = exec_in.imm;
        wr_wreg = 1'b1;
      end
      // Pop only, no data
      op_return_from_irq: begin
        next_result = exec_in.mem_data;
      end
      // Rotate into memory
      op_rotate_left: begin
        next_result = rot_left(exec_in.mem_data, exec_in.mem_data[`CERS_MSB]);
        wr_mem = 1'b1;
      end
      // Rotate into wreg
      op_rotate_left_to_wreg: begin
        next_result = rot_left(exec_in.mem_data, exec_in.mem_data[`CERS_MSB]);
        wr_wreg = 1'b1;
      end
      // Old carry enters bit 0
      op_rotate_left_thru_carry, op_rotate_left_thru_carry_wreg: begin
        next_result = rot_left(exec_in.mem_data, flags_out.carry_flag);
        next_flags.carry_flag = exec_in.mem_data[`CERS_MSB];
        flag_upd.carry_flag = 1'b1;
        wr_mem = (exec_in.op == op_rotate_left_thru_carry);
        wr_wreg = (exec_in.op == op_rotate_left_thru_carry_wreg);
      end
      // Rotate into memory
      op_rotate_right: begin
        next_result = rot_right(exec_in.mem_data, exec_in.mem_data[`CERS_LSB]);
        wr_mem = 1'b1;
      end
      // Rotate into wreg
      op_rotate_right_to_wreg: begin
        next_result = rot_right(exec_in.mem_data, exec_in.mem_data[`CERS_LSB]);
        wr_wreg = 1'b1;
      end
      // Old carry enters bit 7
      op_rotate_right_thru_carry, op_rotate_right_thru_carry_wreg: begin
        next_result = rot_right(exec_in.mem_data, flags_out.carry_flag);
        next_flags.carry_flag = exec_in.mem_data[`CERS_LSB];
        flag_upd.carry_flag = 1'b1;
        wr_mem = (exec_in.op == op_rotate_right_thru_carry);
        wr_wreg = (exec_in.op == op_rotate_right_thru_carry_wreg);
      end
      // Result to wreg
      op_subtract_with_borrow, op_subtract_mem, op_subtract_imm: begin
        next_result = sub_res[7:0];
        next_flags = cers_flags_t'(sub_res[11:8]);
        flag_upd = '1;
        wr_wreg = 1'b1;
      end
      // Result to memory
      op_subtract_with_borrow_to_mem, op_subtract_to_mem: begin
        next_result = sub_res[7:0];
        next_flags = cers_flags_t'(sub_res[11:8]);
        flag_upd = '1;
        wr_mem = 1'b1;
      end
      // Wraps 00 to ff
      op_decrement_skip_zero, op_decrement_skip_zero_wreg: begin
        next_result = exec_in.mem_data - `CERS_BYTE_ONE;
        take_skip = (next_result == `CERS_BYTE_ZERO);
        is_skip = 1'b1;
        wr_mem = (exec_in.op == op_decrement_skip_zero);
        wr_wreg = (exec_in.op == op_decrement_skip_zero_wreg);
      end
      // Wraps ff to 00
      op_increment_skip_zero, op_increment_skip_zero_wreg: begin
        next_result = exec_in.mem_data + `CERS_BYTE_ONE;
        take_skip = (next_result == `CERS_BYTE_ZERO);
        is_skip = 1'b1;
        wr_mem = (exec_in.op == op_increment_skip_zero);
        wr_wreg = (exec_in.op == op_increment_skip_zero_wreg);
      end
      // All ones
      op_set_byte: begin
        next_result = `CERS_BYTE_ONES;
        wr_mem = 1'b1;
      end
      // Other bits kept
      op_set_bit: begin
        next_result = exec_in.mem_data | bit_mask(exec_in.bit_sel);
        wr_mem = 1'b1;
      end
      // No write
      op_bit_test_skip_nonzero: begin
        take_skip = |(exec_in.mem_data & bit_mask(exec_in.bit_sel));
        is_skip = 1'b1;
      end
      // Halves exchanged
      op_swap_nibbles: begin
        next_result = {exec_in.mem_data[`CERS_HALF_MSB:`CERS_LSB],
                       exec_in.mem_data[`CERS_MSB:`CERS_HALF_LSB]};
        wr_mem = 1'b1;
      end
      // Unused codes
      default: begin
        next_result = exec_in.mem_data;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Working register
  // ----------------------------------------------------------------
  // Memory-destination forms never touch it
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wreg_out <= `CERS_WREG_RESET;
    end else if (accept && wr_wreg) begin
      wreg_out <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Per-flag mask, so rotates through carry move only carry; plain rotates and returns move none
  // Refused cycles keep the flags
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flags_out <= `CERS_FLAGS_RESET;
    end else if (accept) begin
      flags_out <= (next_flags & flag_upd) | (flags_out & ~flag_upd);
    end
  end

  // ----------------------------------------------------------------
  // Memory write-back
  // ----------------------------------------------------------------
  // Strobe lasts one cycle; data holds until the next write
  // Saves a mux at the memory side
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mem_we_out <= 1'b0;
      mem_wdata_out <= `CERS_BYTE_ZERO;
    end else begin
      mem_we_out <= accept && wr_mem;
      if (accept && wr_mem) begin
        mem_wdata_out <= next_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Skip sequencing
  // ----------------------------------------------------------------
  // Blocks the next request a cycle
  cers_skip u_skip (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(accept && is_skip),
    .take_in(take_skip),
    .ready_out(skip_ready),
    .skip_out(skip_out),
    .dummy_out(dummy_out)
  );

  // Ready is the sequencer's own flop, passed straight out
  assign ready_out = skip_ready;

  // ----------------------------------------------------------------
  // Returns
  // ----------------------------------------------------------------
  // Returns take effect next cycle
  cers_ret #(
    .PC_W(PC_W)
  ) u_ret (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(accept && is_ret),
    .from_irq_in(is_return_from_irq),
    .irq_pending_in(irq_pending_in),
    .irq_entry_in(irq_entry_in),
    .stack_top_in(stack_top_in),
    .stack_pop_out(stack_pop_out),
    .pc_load_out(pc_load_out),
    .pc_out(pc_out),
    .irq_service_out(irq_service_out),
    .master_irq_enable_out(master_irq_enable_out)
  );

endmodule

/* test/cers_exec_props.sv */
// Concurrent checks on the ports of the execution block
module cers_exec_props
  import cers_pkg::*;
#(
  parameter int PC_W = 13
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire cers_req_t exec_in,
  input wire logic [PC_W-1:0] stack_top_in,
  input wire logic irq_pending_in,
  input wire logic irq_entry_in,
  input wire logic ready_out,
  input wire logic [7:0] wreg_out,
  input wire cers_flags_t flags_out,
  input wire logic master_irq_enable_out,
  input wire logic mem_we_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic pc_load_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic stack_pop_out,
  input wire logic irq_service_out,
  input wire logic skip_out,
  input wire logic dummy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic acc;
  logic [7:0] m_q;
  logic c_q;
  logic bit_q;
  assign acc = exec_in.valid && ready_out;
  // Operand copies, so consequents never slice a past value
  always_ff @(posedge core_clk_in) begin
    m_q <= exec_in.mem_data;
    c_q <= flags_out.carry_flag;
    bit_q <= exec_in.mem_data[exec_in.bit_sel];
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RET_IMM: assert property (acc && exec_in.op == op_return_with_immediate |=> wreg_out == $past(exec_in.imm)
    && flags_out == $past(flags_out) && pc_load_out && stack_pop_out) else $error("return with immediate wrong");
  AST_RETURN_FROM_IRQ: assert property (acc && exec_in.op == op_return_from_irq |=> master_irq_enable_out && stack_pop_out
    && pc_out == $past(stack_top_in) && $stable(flags_out)) else $error("return from irq wrong");
  AST_RETURN_FROM_IRQ_PEND: assert property (acc && exec_in.op == op_return_from_irq
    |=> irq_service_out == $past(irq_pending_in) && pc_load_out) else $error("pending irq not served");
  AST_ROT_L: assert property (acc && exec_in.op == op_rotate_left |=> mem_we_out
    && mem_wdata_out == {m_q[6:0], m_q[7]} && $stable(flags_out)) else $error("rotate left wrong");
  AST_ROT_RC: assert property (acc && exec_in.op == op_rotate_right_thru_carry |=> mem_we_out
    && mem_wdata_out == {c_q, m_q[7:1]} && flags_out.carry_flag == m_q[0]) else $error("rotate right carry wrong");
  AST_SUB_CARRY: assert property (acc && exec_in.op == op_subtract_mem
    |=> flags_out.carry_flag == ($past(wreg_out) >= m_q)) else $error("subtract carry wrong");
  AST_SKIP_TWO: assert property (acc && exec_in.op inside {op_decrement_skip_zero, op_decrement_skip_zero_wreg,
    op_increment_skip_zero, op_increment_skip_zero_wreg, op_bit_test_skip_nonzero}
    |=> dummy_out && !ready_out ##1 ready_out) else $error("skip op not two cycles");
  AST_REFUSE: assert property (!ready_out |=> !mem_we_out && !pc_load_out) else $error("refused request acted");
  AST_SET_BYTE: assert property (acc && exec_in.op == op_set_byte
    |=> mem_we_out && mem_wdata_out == 8'hff && $stable(flags_out)) else $error("byte set wrong");
  AST_BIT_TEST: assert property (acc && exec_in.op == op_bit_test_skip_nonzero
    |=> skip_out == bit_q) else $error("bit test skip wrong");
  AST_SWAP: assert property (acc && exec_in.op == op_swap_nibbles
    |=> mem_we_out && mem_wdata_out == {m_q[3:0], m_q[7:4]}) else $error("swap wrong");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  COV_SKIP: cover property (skip_out && dummy_out);
  COV_PEND: cover property (irq_service_out && pc_load_out);
  COV_REFUSE: cover property (!ready_out && exec_in.valid);
endmodule

bind cers_exec cers_exec_props #(.PC_W(PC_W)) cers_exec_props_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .exec_in(exec_in), .stack_top_in(stack_top_in), .irq_pending_in(irq_pending_in), .irq_entry_in(irq_entry_in),
  .ready_out(ready_out), .wreg_out(wreg_out), .flags_out(flags_out), .master_irq_enable_out(master_irq_enable_out),
  .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .pc_load_out(pc_load_out), .pc_out(pc_out),
  .stack_pop_out(stack_pop_out), .irq_service_out(irq_service_out), .skip_out(skip_out), .dummy_out(dummy_out));

/* test/cers_core_model.sv */
// Return stack and data byte model standing beside the execution block
module cers_core_model
  import cers_pkg::*;
#(
  parameter int PC_W = 13
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic stack_pop_in,
  input wire logic mem_we_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [PC_W-1:0] stack_top_out,
  output logic [7:0] mem_byte_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sp;
  // Distinct entries, so a missed pop shows as a wrong address
  assign stack_top_out = PC_W'(16'h1a5c + 16'(sp) * 16'h0111);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sp <= 2'h0;
    end else if (stack_pop_in) begin
      sp <= sp + 2'h1;
    end
  end
  // Addressed byte, written only on a write strobe
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mem_byte_out <= 8'h00;
    end else if (mem_we_in) begin
      mem_byte_out <= mem_wdata_in;
    end
  end
endmodule

/* test/cers_exec_rotate_sub_skip_test.sv */
// Self-checking bench for the execution block
module cers_exec_rotate_sub_skip_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cers_pkg::*;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
  localparam int PC_W = 13;
  typedef struct packed {
    cers_op_t op; logic [7:0] m; logic [7:0] imm; logic [2:0] b;
    logic [7:0] w; logic [3:0] f; logic we; logic [7:0] wd; logic sk;
  } cers_row_t;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  cers_req_t exec_q = '0;
  logic irq_pending_in = 1'b0;
  logic irq_entry_in = 1'b0;
  logic ready_out, mem_we_out, pc_load_out, stack_pop_out, irq_service_out, skip_out, dummy_out, mie;
  logic [7:0] wreg_out, mem_wdata_out, mem_byte;
  logic [PC_W-1:0] pc_out, stack_top;
  cers_flags_t flags_out;
  int n_fail = 0;
  int num_checks = 0;
  // Chained rows: the carry rotates and subtracts read the carry and working register left by the rows before
  cers_row_t rows [25] = '{
    '{op_rotate_left, 8'h81, 8'h00, 3'h0, 8'h00, 4'h0, 1'b1, 8'h03, 1'b0},
    '{op_rotate_left_to_wreg, 8'h81, 8'h00, 3'h0, 8'h03, 4'h0, 1'b0, 8'h00, 1'b0},
    '{op_rotate_left_thru_carry, 8'h80, 8'h00, 3'h0, 8'h03, 4'h1, 1'b1, 8'h00, 1'b0},
    '{op_rotate_left_thru_carry_wreg, 8'h01, 8'h00, 3'h0, 8'h03, 4'h0, 1'b0, 8'h00, 1'b0},
    '{op_rotate_right, 8'h01, 8'h00, 3'h0, 8'h03, 4'h0, 1'b1, 8'h80, 1'b0},
    '{op_rotate_right_to_wreg, 8'h02, 8'h00, 3'h0, 8'h01, 4'h0, 1'b0, 8'h00, 1'b0},
    '{op_rotate_right_thru_carry, 8'h01, 8'h00, 3'h0, 8'h01, 4'h1, 1'b1, 8'h00, 1'b0},
    '{op_rotate_right_thru_carry_wreg, 8'h02, 8'h00, 3'h0, 8'h81, 4'h0, 1'b0, 8'h00, 1'b0},
    '{op_subtract_mem, 8'h01, 8'h00, 3'h0, 8'h80, 4'h3, 1'b0, 8'h00, 1'b0},
    '{op_subtract_imm, 8'h00, 8'h01, 3'h0, 8'h7f, 4'h9, 1'b0, 8'h00, 1'b0},
    '{op_subtract_with_borrow, 8'h7f, 8'h00, 3'h0, 8'h00, 4'h7, 1'b0, 8'h00, 1'b0},
    '{op_subtract_to_mem, 8'h01, 8'h00, 3'h0, 8'h00, 4'h0, 1'b1, 8'hff, 1'b0},
    '{op_subtract_with_borrow_to_mem, 8'h00, 8'h00, 3'h0, 8'h00, 4'h0, 1'b1, 8'hff, 1'b0},
    '{op_set_byte, 8'h12, 8'h00, 3'h0, 8'h00, 4'h0, 1'b1, 8'hff, 1'b0},
    '{op_set_bit, 8'h00, 8'h00, 3'h5, 8'h00, 4'h0, 1'b1, 8'h20, 1'b0},
    '{op_swap_nibbles, 8'ha5, 8'h00, 3'h0, 8'h00, 4'h0, 1'b1, 8'h5a, 1'b0},
    '{op_return_with_immediate, 8'h00, 8'h3c, 3'h0, 8'h3c, 4'h0, 1'b0, 8'h00, 1'b0},
    '{op_increment_skip_zero, 8'hff, 8'h00, 3'h0, 8'h3c, 4'h0, 1'b1, 8'h00, 1'b1},
    '{op_increment_skip_zero, 8'h10, 8'h00, 3'h0, 8'h3c, 4'h0, 1'b1, 8'h11, 1'b0},
    '{op_decrement_skip_zero, 8'h01, 8'h00, 3'h0, 8'h3c, 4'h0, 1'b1, 8'h00, 1'b1},
    '{op_decrement_skip_zero, 8'h00, 8'h00, 3'h0, 8'h3c, 4'h0, 1'b1, 8'hff, 1'b0},
    '{op_decrement_skip_zero_wreg, 8'h01, 8'h00, 3'h0, 8'h00, 4'h0, 1'b0, 8'h00, 1'b1},
    '{op_increment_skip_zero_wreg, 8'h41, 8'h00, 3'h0, 8'h42, 4'h0, 1'b0, 8'h00, 1'b0},
    '{op_bit_test_skip_nonzero, 8'h08, 8'h00, 3'h3, 8'h42, 4'h0, 1'b0, 8'h00, 1'b1},
    '{op_bit_test_skip_nonzero, 8'hf7, 8'h00, 3'h3, 8'h42, 4'h0, 1'b0, 8'h00, 1'b0}
  };

  // ----------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------
  cers_exec #(.PC_W(PC_W)) cers_exec_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .exec_in(exec_q),
    .stack_top_in(stack_top), .irq_pending_in(irq_pending_in), .irq_entry_in(irq_entry_in), .ready_out(ready_out),
    .wreg_out(wreg_out), .flags_out(flags_out), .master_irq_enable_out(mie), .mem_we_out(mem_we_out),
    .mem_wdata_out(mem_wdata_out), .pc_load_out(pc_load_out), .pc_out(pc_out), .stack_pop_out(stack_pop_out),
    .irq_service_out(irq_service_out), .skip_out(skip_out), .dummy_out(dummy_out));
  cers_core_model #(.PC_W(PC_W)) cers_core_model_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .stack_pop_in(stack_pop_out), .mem_we_in(mem_we_out), .mem_wdata_in(mem_wdata_out),
    .stack_top_out(stack_top), .mem_byte_out(mem_byte));
  always #5 core_clk_in = ~core_clk_in;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_skip(cers_op_t o);
    return o inside {op_decrement_skip_zero, op_decrement_skip_zero_wreg, op_increment_skip_zero,
      op_increment_skip_zero_wreg, op_bit_test_skip_nonzero};
  endfunction
  function automatic logic [PC_W-1:0] stack_val(int i);
    return PC_W'(16'h1a5c + 16'(i) * 16'h0111);
  endfunction
  // One assignment per falling edge, then wait out the accept edge
  task automatic drive(cers_req_t r);
    exec_q = r;
    @(negedge core_clk_in);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge core_clk_in);
    rst_in = 1'b0;
    `CHK(wreg_out, 8'h00)
    `CHK(flags_out, 4'h0)
    `CHK(mie, 1'b0)
    `CHK(ready_out, 1'b1)
    $display("test reset done");
    foreach (rows[i]) begin
      drive('{1'b1, rows[i].op, rows[i].m, rows[i].imm, rows[i].b});
      `CHK(wreg_out, rows[i].w)
      `CHK(flags_out, rows[i].f)
      `CHK(mem_we_out, rows[i].we)
      if (rows[i].we) `CHK(mem_wdata_out, rows[i].wd)
      `CHK(skip_out, rows[i].sk)
      `CHK(dummy_out, is_skip(rows[i].op))
      if (is_skip(rows[i].op)) begin
        `CHK(ready_out, 1'b0)
        drive('{1'b1, op_set_byte, 8'h00, 8'h00, 3'h0});
        `CHK(mem_we_out, 1'b0)
        `CHK(ready_out, 1'b1)
      end
    end
    drive('0);
    `CHK(mem_byte, 8'hff)
    $display("test rows done");
    drive('{1'b1, op_return_from_irq, 8'h00, 8'h00, 3'h0});
    `CHK(pc_load_out & stack_pop_out, 1'b1)
    `CHK(pc_out, stack_val(1))
    `CHK(mie, 1'b1)
    `CHK(irq_service_out, 1'b0)
    `CHK(flags_out, 4'h0)
    irq_entry_in = 1'b1;
    drive('0);
    irq_entry_in = 1'b0;
    irq_pending_in = 1'b1;
    `CHK(mie, 1'b0)
    drive('{1'b1, op_return_from_irq, 8'h00, 8'h00, 3'h0});
    irq_pending_in = 1'b0;
    `CHK(irq_service_out, 1'b1)
    `CHK(pc_out, stack_val(2))
    `CHK(mie, 1'b1)
    `CHK(wreg_out, 8'h42)
    $display("test return from irq done");
    rst_in = 1'b1;
    drive('0);
    rst_in = 1'b0;
    `CHK(wreg_out, 8'h00)
    `CHK(mie, 1'b0)
    `CHK(ready_out, 1'b1)
    $display("test mid-run reset done");
    print_verdict();
  end
  // Run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge core_clk_in);
    n_fail++;
    print_verdict();
  end
endmodule
